// ===== hdl/sbs_pkg.sv
// constants and carrier types shared by the burst memory port, its host model and its bench
`default_nettype none

package sbs_pkg;
  localparam int           SBS_ADDR_W      = 19;
  localparam int           SBS_LANES       = 4;
  localparam int           SBS_LANE_BITS   = 8;
  localparam int           SBS_FIFO_DEPTH  = 32;
  localparam int           SBS_CNT_W       = 2;
  localparam int           SBS_IR_W        = 2;
  localparam logic [1:0]   SBS_CNT_STEP    = 2'h1;
  localparam logic [1:0]   SBS_CNT_RESET   = 2'h0;
  localparam logic [1:0]   SBS_IR_CAPTURE  = 2'h1;
  localparam logic         SBS_STRAP_RESET = 1'b1;

  typedef struct packed {
    logic                     parity;
    logic [SBS_LANE_BITS-1:0] data;
  } sbs_lane_s;

  typedef sbs_lane_s [SBS_LANES-1:0] sbs_word_t;

  typedef struct packed {
    logic [SBS_ADDR_W-1:0] addr;
    logic [SBS_LANES-1:0]  mask;
    sbs_word_t             word;
  } sbs_wr_s;

  typedef struct packed {
    logic [SBS_ADDR_W-1:0] addr;
    logic                  pstb_n;
    logic                  cstb_n;
    logic                  step_n;
    logic                  sel1_n;
    logic                  sel2;
    logic                  sel3_n;
    logic                  lane_en_n;
    logic [SBS_LANES-1:0]  lane_n;
    logic                  all_n;
    logic                  sleep;
    sbs_word_t             word;
  } sbs_pins_s;

  localparam int SBS_WR_W = $bits(sbs_wr_s);

  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SEL_DR = 4'h3,
    TAP_CAP_DR = 4'h2,
    TAP_SH_DR  = 4'h6,
    TAP_EX1_DR = 4'h7,
    TAP_PA_DR  = 4'h5,
    TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc,
    TAP_SEL_IR = 4'hd,
    TAP_CAP_IR = 4'hf,
    TAP_SH_IR  = 4'he,
    TAP_EX1_IR = 4'ha,
    TAP_PA_IR  = 4'hb,
    TAP_EX2_IR = 4'h9,
    TAP_UPD_IR = 4'h8
  } sbs_tap_e;
endpackage : sbs_pkg

`default_nettype wire

// ===== hdl/sbs_fifo.sv
// first-in first-out queue with valid/ready on both sides
`default_nettype none

module sbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0]   wr_ptr;
  logic [PTR_W:0]   rd_ptr;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]) && (wr_ptr[PTR_W] != rd_ptr[PTR_W]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ptr[PTR_W-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr[PTR_W-1:0]] <= in_data;
  end
endmodule : sbs_fifo

`default_nettype wire

// ===== hdl/sbs_sram_port.sv
// pipelined burst static memory: pin interface, burst counter, array, write queue and test port
`default_nettype none

module sbs_sram_port
  import sbs_pkg::*;
#(
  parameter int FIFO_DEPTH = sbs_pkg::SBS_FIFO_DEPTH
) (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic [sbs_pkg::SBS_ADDR_W-1:0] addr,
  input  wire logic                          processor_addr_strobe_n,
  input  wire logic                          controller_addr_strobe_n,
  input  wire logic                          burst_step_n,
  input  wire logic                          chip_select_first_n,
  input  wire logic                          chip_select_second,
  input  wire logic                          chip_select_third_n,
  input  wire logic                          byte_write_enable_n,
  input  wire logic                          byte_select_lane0_n,
  input  wire logic                          byte_select_lane1_n,
  input  wire logic                          byte_select_lane2_n,
  input  wire logic                          byte_select_lane3_n,
  input  wire logic                          all_bytes_write_n,
  input  wire logic                          output_enable_n,
  input  wire logic                          burst_order_strap,
  input  wire logic                          sleep_request,
  input  wire sbs_pkg::sbs_word_t            data_in,
  output sbs_pkg::sbs_word_t                 data_out,
  output logic [sbs_pkg::SBS_LANES-1:0]      data_oe_n,
  output logic                               write_overflow,
  input  wire logic                          tck,
  input  wire logic                          tms,
  input  wire logic                          tdi,
  output logic                               tdo,
  output logic                               tdo_oe_n
);
  import sbs_pkg::*;

  sbs_pins_s             pins;
  sbs_pins_s             p;
  logic                  strap;
  logic                  active;
  logic [SBS_ADDR_W-1:0] addr_reg;
  logic [SBS_CNT_W-1:0]  cnt;
  logic [SBS_CNT_W-1:0]  base;
  logic                  drive;
  sbs_word_t             array [2**SBS_ADDR_W];

  // registered view of the pins; every decision below except pin direction and the test port works on it
  assign pins.addr      = addr;
  assign pins.pstb_n    = processor_addr_strobe_n;
  assign pins.cstb_n    = controller_addr_strobe_n;
  assign pins.step_n    = burst_step_n;
  assign pins.sel1_n    = chip_select_first_n;
  assign pins.sel2      = chip_select_second;
  assign pins.sel3_n    = chip_select_third_n;
  assign pins.lane_en_n = byte_write_enable_n;
  assign pins.lane_n    = {byte_select_lane3_n, byte_select_lane2_n, byte_select_lane1_n, byte_select_lane0_n};
  assign pins.all_n     = all_bytes_write_n;
  assign pins.sleep     = sleep_request;
  assign pins.word      = data_in;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      p     <= '{pstb_n: 1'b1, cstb_n: 1'b1, step_n: 1'b1, sel1_n: 1'b1, sel3_n: 1'b1, lane_en_n: 1'b1,
                 lane_n: '1, all_n: 1'b1, default: '0};
      strap <= SBS_STRAP_RESET;
    end else begin
      p     <= pins;
      strap <= burst_order_strap;
    end
  end

  // access decode
  logic                  selected;
  logic                  pstb_take;
  logic                  cstb_take;
  logic                  start;
  logic                  start_sel;
  logic                  start_desel;
  logic                  cont;
  logic                  step;
  logic [SBS_LANES-1:0]  wr_mask;
  logic                  is_write;
  logic                  do_write;
  logic                  do_read;
  logic [SBS_CNT_W-1:0]  burst_idx;
  logic [SBS_CNT_W-1:0]  lin_next;
  logic [SBS_CNT_W-1:0]  ilv_next;
  logic [SBS_CNT_W-1:0]  step_cnt;
  logic [SBS_CNT_W-1:0]  acc_low;
  logic [SBS_ADDR_W-1:0] acc_addr;

  assign selected    = ~p.sel1_n & p.sel2 & ~p.sel3_n;
  assign pstb_take   = ~p.pstb_n & ~p.sel1_n;
  assign cstb_take   = ~p.cstb_n & ~pstb_take;
  assign start       = (pstb_take | cstb_take) & ~p.sleep;
  assign start_sel   = start & selected;
  assign start_desel = start & ~selected;
  assign cont        = active & ~start & ~p.sleep;
  assign step        = cont & ~p.step_n;

  // all-bytes write overrides, otherwise lane selects count only with the enable
  assign wr_mask  = ~p.all_n ? '1 : (~p.lane_en_n ? ~p.lane_n : '0);
  assign is_write = |wr_mask;

  // processor-strobe first cycle ignores the write controls
  assign do_write = (start_sel & cstb_take & is_write) | (cont & is_write);
  assign do_read  = (start_sel & ~(cstb_take & is_write)) | (cont & ~is_write);

  // wraparound counter: linear adds one, interleaved flips by step index
  assign burst_idx = cnt ^ base;
  assign lin_next  = cnt + SBS_CNT_STEP;
  assign ilv_next  = base ^ (burst_idx + SBS_CNT_STEP);
  assign step_cnt  = strap ? ilv_next : lin_next;
  assign acc_low   = step ? step_cnt : cnt;
  assign acc_addr  = start_sel ? p.addr : {addr_reg[SBS_ADDR_W-1:SBS_CNT_W], acc_low};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active   <= 1'b0;
      addr_reg <= '0;
      cnt      <= SBS_CNT_RESET;
      base     <= SBS_CNT_RESET;
    end else if (start_sel) begin
      active   <= 1'b1;
      addr_reg <= p.addr;
      cnt      <= p.addr[SBS_CNT_W-1:0];
      base     <= p.addr[SBS_CNT_W-1:0];
    end else if (start_desel) begin
      active   <= 1'b0;
    end else if (step) begin
      cnt      <= step_cnt;
    end
  end

  // writes pass through the queue; sleep stalls the drain and also blocks new writes from entering it
  sbs_wr_s wr_entry;
  sbs_wr_s head;
  logic    fifo_ready;
  logic    head_valid;
  logic    drain;
  logic    push;

  assign wr_entry = '{addr: acc_addr, mask: wr_mask, word: p.word};
  assign push     = do_write & fifo_ready;
  assign drain    = head_valid & ~p.sleep;

  sbs_fifo #(
    .WIDTH (SBS_WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_valid  (do_write),
    .in_ready  (fifo_ready),
    .in_data   (wr_entry),
    .out_valid (head_valid),
    .out_ready (drain),
    .out_data  (head)
  );

  always_ff @(posedge core_clk) begin
    if (drain) begin
      for (int i = 0; i < SBS_LANES; i++) begin
        if (head.mask[i]) array[head.addr][i] <= head.word[i];
      end
    end
  end

  // read word with the draining write merged in per lane
  sbs_word_t array_word;
  sbs_word_t rd_word;
  logic      head_hit;

  assign array_word = array[acc_addr];
  assign head_hit   = drain & (head.addr == acc_addr);

  for (genvar g = 0; g < SBS_LANES; g++) begin : g_lane
    assign rd_word[g] = (head_hit & head.mask[g]) ? head.word[g] : array_word[g];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drive          <= 1'b0;
      data_out       <= '0;
      write_overflow <= 1'b0;
    end else begin
      drive          <= do_read;
      data_out       <= do_read ? rd_word : data_out;
      write_overflow <= do_write & ~fifo_ready;
    end
  end

  // pin direction follows the output enable without waiting for a clock
  assign data_oe_n = {SBS_LANES{~(drive & ~output_enable_n)}};

  // test access port, test clock sampled in the core clock domain
  sbs_tap_e            tap;
  sbs_tap_e            next_tap;
  logic                tck_q;
  logic                tck_prev;
  logic                tms_q;
  logic                tdi_q;
  logic                tck_rise;
  logic                tck_fall;
  logic                bypass;
  logic [SBS_IR_W-1:0] ir_shift;

  assign tck_rise = tck_q & ~tck_prev;
  assign tck_fall = ~tck_q & tck_prev;

  always_comb begin
    unique case (tap)
      TAP_RESET:  next_tap = tms_q ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   next_tap = tms_q ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms_q ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms_q ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_tap = tms_q ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = tms_q ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  next_tap = tms_q ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_tap = tms_q ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = tms_q ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms_q ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms_q ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_tap = tms_q ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = tms_q ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  next_tap = tms_q ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_tap = tms_q ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = tms_q ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tck_q    <= 1'b0;
      tck_prev <= 1'b0;
      tms_q    <= 1'b1;
      tdi_q    <= 1'b0;
    end else begin
      tck_q    <= tck;
      tck_prev <= tck_q;
      tms_q    <= tms;
      tdi_q    <= tdi;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tap      <= TAP_RESET;
      bypass   <= 1'b0;
      ir_shift <= SBS_IR_CAPTURE;
    end else if (tck_rise) begin
      tap      <= next_tap;
      bypass   <= (tap == TAP_SH_DR) ? tdi_q : ((tap == TAP_CAP_DR) ? 1'b0 : bypass);
      ir_shift <= (tap == TAP_SH_IR) ? {tdi_q, ir_shift[SBS_IR_W-1:1]}
                : ((tap == TAP_CAP_IR) ? SBS_IR_CAPTURE : ir_shift);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= (tap == TAP_SH_IR) ? ir_shift[0] : bypass;
      tdo_oe_n <= ~((tap == TAP_SH_IR) | (tap == TAP_SH_DR));
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_pstb_accept;
    pstb_take && selected && !p.sleep;
  endsequence

  sequence s_cstb_accept;
    cstb_take && selected && !p.sleep;
  endsequence

  sequence s_asleep;
    p.sleep [*2];
  endsequence

  select_decode_a: assert property (start && !selected |=> !active)
    else $error("deselect strobe left the device active");
  pstb_ignored_a: assert property (!p.pstb_n && p.sel1_n && p.cstb_n |=> $stable(addr_reg))
    else $error("processor strobe acted while first select high");
  pstb_load_a: assert property (s_pstb_accept |=> addr_reg == $past(p.addr) && cnt == $past(p.addr[1:0]))
    else $error("processor strobe did not load address and counter");
  cstb_load_a: assert property (s_cstb_accept |=> addr_reg == $past(p.addr) && cnt == $past(p.addr[1:0]))
    else $error("controller strobe did not load address and counter");
  strobe_priority_a: assert property (s_pstb_accept and !p.cstb_n |-> !push)
    else $error("controller strobe write taken beside processor strobe");
  burst_advance_a: assert property (step |=> cnt != $past(cnt) && $stable(addr_reg))
    else $error("burst step did not move the counter");
  linear_step_a: assert property (step && !strap |=> cnt == $past(cnt) + 2'h1)
    else $error("linear burst did not add one");
  interleave_step_a: assert property (step && strap |=> (cnt ^ base) == $past(cnt ^ base) + 2'h1)
    else $error("interleaved burst index did not advance");
  byte_qualify_a: assert property (push |-> !p.all_n || (!p.lane_en_n && wr_entry.mask == ~p.lane_n))
    else $error("byte write without enable");
  global_write_a: assert property (push && !p.all_n |-> wr_entry.mask == '1)
    else $error("all-bytes write missed a lane");
  read_pipe_a: assert property (do_read |=> drive ##0 data_out == $past(rd_word))
    else $error("read data not presented one clock after address");
  deselect_float_a: assert property (start_desel |=> !drive ##1 (drive == $past(do_read)))
    else $error("data pins driven while deselected");
  first_read_mask_a: assert property (start_sel && !active |-> !drive && data_oe_n == '1)
    else $error("first clock after deselect drove the pins");
  oe_steer_a: assert property (drive && !output_enable_n |-> data_oe_n == '0)
    else $error("output enable did not drive the pins");
  sleep_hold_a: assert property (s_asleep |-> !drain && !drive && !start)
    else $error("activity during sleep");
  tdo_edge_a: assert property ($changed(tdo) |-> $past(tck_fall))
    else $error("serial output changed off the falling test clock");
  tap_edge_a: assert property ($changed(tap) && !$past(sys_rst) |-> $past(tck_rise))
    else $error("test state moved off the rising test clock");
endmodule : sbs_sram_port

`default_nettype wire

// ===== tb/sbs_host_model.sv
// host-side model: drives the memory pins and resolves the shared data bus
`default_nettype none

module sbs_host_model (
  input  wire logic                           core_clk,
  input  wire sbs_pkg::sbs_word_t             data_out,
  input  wire logic [sbs_pkg::SBS_LANES-1:0]  data_oe_n,
  output sbs_pkg::sbs_pins_s                  pins,
  output logic                                output_enable_n,
  output logic                                burst_order_strap,
  output sbs_pkg::sbs_word_t                  data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;

  logic drv;
  logic junk;

  initial begin
    pins = '1;
    pins.sel1_n = 1'b0;
    pins.sel3_n = 1'b0;
    pins.sleep = 1'b0;
    output_enable_n = 1'b1;
    drv = 1'b0;
    junk = 1'b0;
    burst_order_strap = SBS_STRAP_RESET;
  end

  // write data only goes out while the device's drivers are off
  task automatic put(input sbs_pins_s p, input logic oe, input logic d);
    pins = p;
    output_enable_n = oe;
    drv = d;
  endtask : put

  // strap only moves while the bus is idle
  task automatic set_strap(input logic s);
    burst_order_strap = s;
  endtask : set_strap

  always @(posedge core_clk) begin
    junk <= ~junk;
  end

  // a released bus toggles every cycle instead of holding a stale value
  assign data_in = !data_oe_n[0] ? data_out : (drv ? pins.word : {$bits(sbs_word_t){junk}});
endmodule : sbs_host_model

`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the burst memory port
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;

  logic                 core_clk;
  logic                 sys_rst;
  logic                 tck;
  logic                 tms;
  logic                 tdi;
  sbs_pins_s            pins;
  logic                 oe_n;
  logic                 strap;
  sbs_word_t            data_in;
  sbs_word_t            data_out;
  logic [SBS_LANES-1:0] data_oe_n;
  logic                 write_overflow;
  logic                 tdo;
  logic                 tdo_oe_n;
  sbs_word_t            ref_mem [0:11];
  int                   fail_count;
  int                   check_count;

  sbs_host_model host (.core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n), .pins(pins),
    .output_enable_n(oe_n), .burst_order_strap(strap), .data_in(data_in));

  sbs_sram_port #(.FIFO_DEPTH(4)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .addr(pins.addr),
    .processor_addr_strobe_n(pins.pstb_n), .controller_addr_strobe_n(pins.cstb_n),
    .burst_step_n(pins.step_n), .chip_select_first_n(pins.sel1_n), .chip_select_second(pins.sel2),
    .chip_select_third_n(pins.sel3_n), .byte_write_enable_n(pins.lane_en_n),
    .byte_select_lane0_n(pins.lane_n[0]), .byte_select_lane1_n(pins.lane_n[1]),
    .byte_select_lane2_n(pins.lane_n[2]), .byte_select_lane3_n(pins.lane_n[3]),
    .all_bytes_write_n(pins.all_n), .output_enable_n(oe_n), .burst_order_strap(strap),
    .sleep_request(pins.sleep), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .write_overflow(write_overflow), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  always #4 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  function automatic sbs_pins_s idle_p();
    sbs_pins_s p;
    p = '1;
    p.sel1_n = 1'b0;
    p.sel3_n = 1'b0;
    p.sleep = 1'b0;
    return p;
  endfunction : idle_p

  function automatic sbs_word_t rw();
    logic [63:0] r;
    r = {$urandom, $urandom};
    return r[35:0];
  endfunction : rw

  function automatic sbs_word_t merge(sbs_word_t o, sbs_word_t n, logic [3:0] m);
    merge = o;
    for (int i = 0; i < SBS_LANES; i++) begin
      if (m[i]) merge[i] = n[i];
    end
  endfunction : merge

  task automatic wr(input int a, input sbs_word_t d, input logic byt, input logic bw, input logic [3:0] ln);
    sbs_pins_s p;
    p = idle_p();
    p.addr = SBS_ADDR_W'(a);
    p.cstb_n = 1'b0;
    p.all_n = byt;
    p.lane_en_n = bw;
    p.lane_n = ln;
    p.word = d;
    @(negedge core_clk);
    host.put(p, 1'b1, 1'b1);
    @(negedge core_clk);
    host.put(idle_p(), 1'b1, 1'b0);
    if (!byt) ref_mem[a] = d;
    else if (!bw) ref_mem[a] = merge(ref_mem[a], d, ~ln);
  endtask : wr

  task automatic rd(input int a, input logic fresh, input logic both);
    sbs_pins_s p;
    p = idle_p();
    p.addr = SBS_ADDR_W'(a);
    p.pstb_n = 1'b0;
    p.cstb_n = ~both;
    p.all_n = ~both;
    p.word = rw();
    @(negedge core_clk);
    host.put(p, 1'b0, 1'b0);
    @(negedge core_clk);
    host.put(idle_p(), 1'b0, 1'b0);
    if (fresh) chk("first clock drive", 36'(data_oe_n), 36'hf);
    @(negedge core_clk);
    chk("read data", data_out, ref_mem[a]);
    chk("read drive", 36'(data_oe_n), 36'h0);
  endtask : rd

  task automatic burst(input int st, input logic lin);
    sbs_pins_s p;
    for (int i = 0; i < 6; i++) begin
      p = idle_p();
      p.addr = SBS_ADDR_W'(8 + st);
      p.pstb_n = (i != 0);
      p.step_n = (i == 0) || (i > 3);
      @(negedge core_clk);
      if (i >= 2) chk("burst data", data_out, ref_mem[8 + (lin ? ((st + i - 2) & 3) : (st ^ (i - 2)))]);
      host.put(p, 1'b0, 1'b0);
    end
  endtask : burst

  task automatic tap(input logic m);
    @(negedge core_clk);
    tms = m;
    tdi = 1'($urandom);
    tck = 1'b1;
    repeat (3) @(negedge core_clk);
    tck = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : tap

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    sbs_pins_s p;
    core_clk = 1'b0;
    sys_rst = 1'b1;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(78995));
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("reset drive", 36'(data_oe_n), 36'hf);
    chk("reset data", data_out, 36'h0);
    chk("reset overflow", 36'(write_overflow), 36'h0);
    chk("reset tdo enable", 36'(tdo_oe_n), 36'h1);
    repeat (5) tap(1'b1);
    chk("tap reset enable", 36'(tdo_oe_n), 36'h1);
    tap(1'b0);
    tap(1'b1);
    tap(1'b1);
    tap(1'b0);
    tap(1'b0);
    chk("shift enable", 36'(tdo_oe_n), 36'h0);
    chk("ir capture bit", 36'(tdo), 36'h1);
    for (int a = 0; a < 12; a++) begin
      wr(a, rw(), 1'b0, 1'($urandom), 4'($urandom));
    end
    rd(0, 1'b0, 1'b0);
    #1 host.put(idle_p(), 1'b1, 1'b0);
    #1 chk("async release", 36'(data_oe_n), 36'hf);
    host.put(idle_p(), 1'b0, 1'b0);
    #1 chk("async drive", 36'(data_oe_n), 36'h0);
    for (int k = 0; k < 3; k++) begin
      p = idle_p();
      p.cstb_n = 1'b0;
      p.sel1_n = (k == 0);
      p.sel2 = (k != 1);
      p.sel3_n = (k == 2);
      @(negedge core_clk);
      host.put(p, 1'b0, 1'b0);
      @(negedge core_clk);
      host.put(idle_p(), 1'b0, 1'b0);
      @(negedge core_clk);
      chk("deselect drive", 36'(data_oe_n), 36'hf);
      rd(k, 1'b1, 1'b0);
    end
    p = idle_p();
    p.pstb_n = 1'b0;
    p.sel1_n = 1'b1;
    p.addr = SBS_ADDR_W'(5);
    @(negedge core_clk);
    host.put(p, 1'b0, 1'b0);
    @(negedge core_clk);
    host.put(idle_p(), 1'b0, 1'b0);
    @(negedge core_clk);
    chk("ignored strobe", data_out, ref_mem[2]);
    rd(6, 1'b0, 1'b1);
    rd(6, 1'b0, 1'b0);
    p = idle_p();
    p.sleep = 1'b1;
    p.pstb_n = 1'b0;
    p.addr = SBS_ADDR_W'(9);
    @(negedge core_clk);
    host.put(p, 1'b0, 1'b0);
    repeat (4) @(negedge core_clk);
    chk("sleep drive", 36'(data_oe_n), 36'hf);
    host.put(idle_p(), 1'b0, 1'b0);
    rd(3, 1'b0, 1'b0);
    for (int s = 0; s < 2; s++) begin
      repeat (2) @(negedge core_clk);
      host.set_strap(s[0]);
      for (int st = 0; st < 4; st++) begin
        burst(st, ~s[0]);
      end
    end
    for (int n = 0; n < 60; n++) begin
      int a;
      a = $urandom_range(0, 11);
      case ($urandom_range(0, 3))
        0: wr(a, rw(), 1'b0, 1'($urandom), 4'($urandom));
        1: wr(a, rw(), 1'b1, 1'($urandom), 4'($urandom));
        default: rd(a, 1'b0, 1'b0);
      endcase
    end
    final_report();
  end
endmodule : tb

`default_nettype wire
